// [core/fps_map.svh]
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// selector register reset value and field positions
`define FPS_SEL_RESET      8'h00
`define FPS_SEL_TWO_MSB    7
`define FPS_SEL_TWO_LSB    4
`define FPS_SEL_ONE_MSB    3
`define FPS_SEL_ONE_LSB    0

// source codes, common to both pins
`define FPS_CODE_FILT0     4'h0
`define FPS_CODE_FILT1     4'h1
`define FPS_CODE_WAKE      4'h2
// pin-specific codes
`define FPS_CODE_TWO_MODE_CHANGE_FLAG  4'h3
`define FPS_CODE_TWO_RXMT  4'h8
`define FPS_CODE_ONE_BERR  4'h3
`define FPS_CODE_ONE_TXDN  4'h4
`define FPS_CODE_ONE_RXQ   4'h6
`define FPS_CODE_ONE_TXFL  4'hf

`endif

// [core/fps_pkg.sv]
package fps_pkg;

  // flags offered to the pin selectors
  typedef struct packed {
    logic filter_zero_hit;
    logic filter_one_hit;
    logic wake_flag;
    logic mode_change_flag;
    logic bus_error_flag;
    logic tx_done_flag;
    logic rx_queue_flag;
    logic rx_queue_empty;
    logic tx_queue_full;
  } fps_flags_type;

  typedef struct packed {
    logic [3:0] second_pin_source_select;
    logic [3:0] first_pin_source_select;
  } fps_sel_type;

endpackage

// [core/fps_flag_to_pin_selector.sv]
`timescale 1ns/100ps
`include "fps_map.svh"

// Notes on behaviour
// - bits 7..4 pick the second pin source; read/write; reset to zero.
// - bits 3..0 pick the first pin source; read/write; reset to zero.
// - codes 0,1,2 follow filter zero, filter one and wake flags on either pin.
// - second pin code 3 follows the mode change flag.
// - first pin code 3 follows the bus error flag.
// - first pin code 4 follows the transmission complete flag.
// - first pin code 6 follows the receive queue flag.
// - second pin code 8 follows the receive queue empty flag.
// - first pin code 15 follows the transmit queue full flag.
// - programmed selection shows flag values on the pins without a register read.
module fps_flag_to_pin_selector (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  sel_wr,
  input  wire logic [7:0]            sel_wdata,
  input  wire fps_pkg::fps_flags_type flags,
  output logic [7:0]                 sel_rdata,
  output logic                       aux_output_one,
  output logic                       aux_output_two
);
  import fps_pkg::*;

  // ------------------------------------------------------------
  // selector register
  // ------------------------------------------------------------
  // written by the serial port block, which keeps mode 0 framing
  fps_sel_type sel;
  fps_sel_type next_sel;

  always_comb begin
    next_sel = sel;
    if (sel_wr) begin
      next_sel.second_pin_source_select = sel_wdata[`FPS_SEL_TWO_MSB:`FPS_SEL_TWO_LSB];
      next_sel.first_pin_source_select  = sel_wdata[`FPS_SEL_ONE_MSB:`FPS_SEL_ONE_LSB];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel <= fps_sel_type'(`FPS_SEL_RESET);
    end else begin
      sel <= next_sel;
    end
  end

  // ------------------------------------------------------------
  // source decode
  // ------------------------------------------------------------
  // codes not listed read as reserved and keep the pin low
  function automatic logic pick_two(input logic [3:0] code, input fps_flags_type f);
    case (code)
      `FPS_CODE_FILT0:    pick_two = f.filter_zero_hit;
      `FPS_CODE_FILT1:    pick_two = f.filter_one_hit;
      `FPS_CODE_WAKE:     pick_two = f.wake_flag;
      `FPS_CODE_TWO_MODE_CHANGE_FLAG: pick_two = f.mode_change_flag;
      `FPS_CODE_TWO_RXMT: pick_two = f.rx_queue_empty;
      default:            pick_two = 1'b0;
    endcase
  endfunction

  function automatic logic pick_one(input logic [3:0] code, input fps_flags_type f);
    case (code)
      `FPS_CODE_FILT0:    pick_one = f.filter_zero_hit;
      `FPS_CODE_FILT1:    pick_one = f.filter_one_hit;
      `FPS_CODE_WAKE:     pick_one = f.wake_flag;
      `FPS_CODE_ONE_BERR: pick_one = f.bus_error_flag;
      `FPS_CODE_ONE_TXDN: pick_one = f.tx_done_flag;
      `FPS_CODE_ONE_RXQ:  pick_one = f.rx_queue_flag;
      `FPS_CODE_ONE_TXFL: pick_one = f.tx_queue_full;
      default:            pick_one = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  // one clock of latency buys glitch-free pins off a mux
  logic       next_one;
  logic       next_two;
  logic [7:0] next_rdata;

  always_comb begin
    next_one   = pick_one(sel.first_pin_source_select, flags);
    next_two   = pick_two(sel.second_pin_source_select, flags);
    next_rdata = next_sel;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_output_one <= 1'b0;
      aux_output_two <= 1'b0;
      sel_rdata      <= `FPS_SEL_RESET;
    end else begin
      aux_output_one <= next_one;
      aux_output_two <= next_two;
      sel_rdata      <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // every attempt except a_reset_clear and a_sel_readback_held needs reset sampled high: at the release edge the output flops
  // are still held in reset, so a check launched there would compare stale values
  logic [7:0] chk_last_wr;
  logic [7:0] next_chk_last_wr;

  always_comb begin
    next_chk_last_wr = chk_last_wr;
    if (sel_wr) begin
      next_chk_last_wr = sel_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_last_wr <= `FPS_SEL_RESET;
    end else begin
      chk_last_wr <= next_chk_last_wr;
    end
  end

  // register and reset
  a_reset_clear: assert property (
    @(posedge sys_clk)
    !rst_b |=> sel_rdata == `FPS_SEL_RESET && !aux_output_one && !aux_output_two)
    else $error("outputs not cleared by reset");
  a_sel_write_kept: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel_wr |=> sel_rdata == $past(sel_wdata))
    else $error("readback differs from write");
  a_sel_field_high: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel_wr |=> sel.second_pin_source_select == $past(sel_wdata[7:4]))
    else $error("high field wrong");
  a_sel_field_low: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel_wr |=> sel.first_pin_source_select == $past(sel_wdata[3:0]))
    else $error("low field wrong");
  a_sel_no_write: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && !sel_wr |=> $stable(sel))
    else $error("selector changed without a write");
  a_sel_readback_held: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    sel_rdata == chk_last_wr)
    else $error("readback lost between writes");

  // pin one
  a_one_filter_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == `FPS_CODE_FILT0 |=> aux_output_one == $past(flags.filter_zero_hit))
    else $error("pin one not following filter zero");
  a_one_filter_one: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == `FPS_CODE_FILT1 |=> aux_output_one == $past(flags.filter_one_hit))
    else $error("pin one not following filter one");
  a_one_wake: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == `FPS_CODE_WAKE |=> aux_output_one == $past(flags.wake_flag))
    else $error("pin one not following wake");
  a_one_bus_err: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == `FPS_CODE_ONE_BERR |=> aux_output_one == $past(flags.bus_error_flag))
    else $error("pin one not following bus error");
  a_one_tx_done: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == `FPS_CODE_ONE_TXDN |=> aux_output_one == $past(flags.tx_done_flag))
    else $error("pin one not following tx done");
  a_one_rx_queue: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == `FPS_CODE_ONE_RXQ |=> aux_output_one == $past(flags.rx_queue_flag))
    else $error("pin one not following rx queue");
  a_one_tx_full: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == `FPS_CODE_ONE_TXFL |=> aux_output_one == $past(flags.tx_queue_full))
    else $error("pin one not following tx full");
  // codes with no mapped source keep the pin low
  a_one_reserved_low: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select == 4'h5 |=> !aux_output_one)
    else $error("reserved code drove pin one");
  a_one_reserved_rest: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.first_pin_source_select inside {[4'h7:4'he]} |=> !aux_output_one)
    else $error("reserved code drove pin one");

  // pin two
  a_two_filter_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.second_pin_source_select == `FPS_CODE_FILT0 |=> aux_output_two == $past(flags.filter_zero_hit))
    else $error("pin two not following filter zero");
  a_two_filter_one: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.second_pin_source_select == `FPS_CODE_FILT1 |=> aux_output_two == $past(flags.filter_one_hit))
    else $error("pin two not following filter one");
  a_two_wake: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.second_pin_source_select == `FPS_CODE_WAKE |=> aux_output_two == $past(flags.wake_flag))
    else $error("pin two not following wake");
  a_two_mode_chg: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.second_pin_source_select == `FPS_CODE_TWO_MODE_CHANGE_FLAG |=> aux_output_two == $past(flags.mode_change_flag))
    else $error("pin two not following mode change");
  a_two_rx_empty: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.second_pin_source_select == `FPS_CODE_TWO_RXMT |=> aux_output_two == $past(flags.rx_queue_empty))
    else $error("pin two not following rx empty");
  // codes with no mapped source keep the pin low
  a_two_reserved_mid: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.second_pin_source_select inside {[4'h4:4'h7]} |=> !aux_output_two)
    else $error("reserved code drove pin two");
  a_two_reserved_top: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rst_b && sel.second_pin_source_select inside {[4'h9:4'hf]} |=> !aux_output_two)
    else $error("reserved code drove pin two");

endmodule

// [tb/fps_host_watch.sv]
`timescale 1ns/100ps
// ----------------------------------------
// host side: watches the pins, never reads
// ----------------------------------------
module fps_host_watch (
  input  wire logic       sys_clk,
  input  wire logic       probe,
  input  wire logic [9:0] pins_in,
  output logic            seen,
  output logic [9:0]      got
);
  // one sample per probe, so the bench decides when pins must have settled
  always_ff @(posedge sys_clk) begin
    seen <= probe;
    got  <= pins_in;
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
`define CHK(n, x, y) begin comparisons++; if ((x) !== (y)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", n, x, y); end end
module testbench;
  import fps_pkg::*;
  logic          sys_clk = 1'b0, rst_b = 1'b0, sel_wr = 1'b0, probe = 1'b0, seen, p1, p2;
  logic [7:0]    sel_wdata = 8'h00, rdata;
  fps_flags_type flags = '0;
  logic [9:0]    got, e;
  logic [9:0]    expq[$];
  logic [31:0]   rs = 32'h36;
  int            error_cnt = 0, comparisons = 0;
  // ----------------------------------------
  // clock, design, host model
  // ----------------------------------------
  initial forever #50 sys_clk = ~sys_clk;
  fps_flag_to_pin_selector dut (.sys_clk(sys_clk), .rst_b(rst_b), .sel_wr(sel_wr), .sel_wdata(sel_wdata),
    .flags(flags), .sel_rdata(rdata), .aux_output_one(p1), .aux_output_two(p2));
  fps_host_watch host (.sys_clk(sys_clk), .probe(probe), .pins_in({rdata, p2, p1}), .seen(seen), .got(got));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic pick(input logic [3:0] c, input logic two, input fps_flags_type f);
    case (c)
      4'h0: return f.filter_zero_hit;
      4'h1: return f.filter_one_hit;
      4'h2: return f.wake_flag;
      4'h3: return two ? f.mode_change_flag : f.bus_error_flag;
      4'h4: return two ? 1'b0 : f.tx_done_flag;
      4'h6: return two ? 1'b0 : f.rx_queue_flag;
      4'h8: return two ? f.rx_queue_empty : 1'b0;
      4'hf: return two ? 1'b0 : f.tx_queue_full;
      default: return 1'b0;
    endcase
  endfunction
  // write (or not), new random flags, then let the host look after two settle edges
  task automatic step(input logic [7:0] s, input logic do_wr);
    @(posedge sys_clk);
    rs = xs(rs);
    sel_wr <= do_wr;
    sel_wdata <= s;
    flags <= fps_flags_type'(rs[8:0]);
    @(posedge sys_clk);
    sel_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    expq.push_back({s, pick(s[7:4], 1'b1, flags), pick(s[3:0], 1'b0, flags)});
    probe <= 1'b1;
    @(posedge sys_clk);
    probe <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // checking
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (seen === 1'b1) begin
      e = expq.pop_front();
      `CHK("sel_rdata", e[9:2], got[9:2])
      `CHK("aux_output_two", e[1], got[1])
      `CHK("aux_output_one", e[0], got[0])
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    step(8'h00, 1'b0);
    // every code on both pins, then random selections
    for (int i = 0; i < 16; i++) begin
      step({i[3:0], 4'hf - i[3:0]}, 1'b1);
    end
    for (int i = 0; i < 24; i++) begin
      rs = xs(rs);
      step(rs[7:0], 1'b1);
    end
    // a known write, then a reset in mid-run must bring the register back to zero
    step(8'h83, 1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    step(8'h00, 1'b0);
    repeat (3) @(posedge sys_clk);
    report_and_stop;
  end
  // the run needs about 220 cycles; allow far more before calling it hung
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
endmodule
